/* File: include/cpr_pkg.sv */
// Constants and types shared by the CPU program and system register block.
`default_nettype none
package cpr_pkg;
  localparam int XLEN      = 32;
  localparam int GPR_COUNT = 32;
  localparam int GPR_AW    = 5;
  localparam int SR_AW     = 5;
  localparam int PC_AW     = 26;
  localparam int STEP_W    = 3;
  localparam int CODE_W    = 16;

  localparam logic [GPR_AW-1:0] GPR_ZERO = 5'h00;
  localparam logic [GPR_AW-1:0] GPR_EP   = 5'h1e;

  // Fetch address mask and the wider mask for saved PCs, which may hold an odd value.
  localparam logic [XLEN-1:0] PC_MASK      = 32'h03ff_fffe;
  localparam logic [XLEN-1:0] PC_SAVE_MASK = 32'h03ff_ffff;
  localparam logic [XLEN-1:0] PSW_MASK     = 32'h0000_00ff;
  localparam logic [XLEN-1:0] PC_RESET     = 32'h0000_0000;
  localparam logic [XLEN-1:0] PSW_RESET    = 32'h0000_0020;
  localparam logic [XLEN-1:0] WORD_ZERO    = 32'h0000_0000;

  // Status bits forced on when an event other than a table call is taken.
  localparam logic [XLEN-1:0] PSW_SET_MASKABLE = 32'h0000_0020;
  localparam logic [XLEN-1:0] PSW_SET_SW_EXC   = 32'h0000_0060;
  localparam logic [XLEN-1:0] PSW_SET_NMI      = 32'h0000_00a0;
  localparam logic [XLEN-1:0] PSW_SET_DEBUG    = 32'h0000_00e0;
  localparam int              PSW_NMI_BIT      = 7;

  // Cause register: low half for maskable and exception codes, high half for NMI.
  localparam int ECR_NMI_LSB = 16;

  localparam logic [SR_AW-1:0] SR_INT_PC     = 5'h00;
  localparam logic [SR_AW-1:0] SR_INT_STATUS = 5'h01;
  localparam logic [SR_AW-1:0] SR_NMI_PC     = 5'h02;
  localparam logic [SR_AW-1:0] SR_NMI_STATUS = 5'h03;
  localparam logic [SR_AW-1:0] SR_CAUSE      = 5'h04;
  localparam logic [SR_AW-1:0] SR_STATUS     = 5'h05;
  localparam logic [SR_AW-1:0] SR_TC_PC      = 5'h10;
  localparam logic [SR_AW-1:0] SR_TC_STATUS  = 5'h11;
  localparam logic [SR_AW-1:0] SR_DBG_PC     = 5'h12;
  localparam logic [SR_AW-1:0] SR_DBG_STATUS = 5'h13;
  localparam logic [SR_AW-1:0] SR_TC_BASE    = 5'h14;

  typedef enum logic [2:0] {
    EV_NONE,
    EV_MASKABLE,
    EV_SW_EXC,
    EV_NMI,
    EV_DEBUG,
    EV_TABLE_CALL
  } cpr_event_kind_t;

  typedef struct packed {
    cpr_event_kind_t   kind;
    logic [XLEN-1:0]   resume_pc;
    logic [XLEN-1:0]   handler_pc;
    logic [CODE_W-1:0] code;
  } cpr_event_t;

  typedef struct packed {
    logic [SR_AW-1:0] num;
    logic [XLEN-1:0]  data;
  } cpr_sr_req_t;
endpackage
`default_nettype wire

/* File: logic/cpr_gpr_bank.sv */
// General register bank with registered read ports and the short-access base pointer.
`default_nettype none
module cpr_gpr_bank
  import cpr_pkg::*;
#(
  parameter int COUNT = GPR_COUNT,
  parameter int AW    = GPR_AW,
  parameter int W     = XLEN
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // Read ports
  input  wire logic [AW-1:0] rd_a_addr_i,
  input  wire logic [AW-1:0] rd_b_addr_i,
  output logic      [W-1:0]  rd_a_o,
  output logic      [W-1:0]  rd_b_o,
  output logic      [W-1:0]  short_base_o,
  // Write port
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [W-1:0]  wr_data_i
);
  logic [W-1:0] bank_r [COUNT];
  logic         wr_ok;

  assign wr_ok = wr_en_i && (wr_addr_i != AW'(GPR_ZERO));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < COUNT; i++) begin
        bank_r[i] <= '0;
      end
    end else if (wr_ok) begin
      bank_r[wr_addr_i] <= wr_data_i;
    end
  end

  // A write in the same cycle is passed through so a reader never sees a stale word.
  function automatic logic [W-1:0] read_word(input logic [AW-1:0] a);
    logic [W-1:0] v;
    v = bank_r[a];
    if (wr_ok && wr_addr_i == a) begin
      v = wr_data_i;
    end
    if (a == AW'(GPR_ZERO)) begin
      v = '0;
    end
    return v;
  endfunction

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_a_o       <= '0;
      rd_b_o       <= '0;
      short_base_o <= '0;
    end else begin
      rd_a_o       <= read_word(rd_a_addr_i);
      rd_b_o       <= read_word(rd_b_addr_i);
      short_base_o <= read_word(AW'(GPR_EP));
    end
  end

  a_zero_read: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_a_addr_i == AW'(GPR_ZERO) |=> rd_a_o == '0)
    else $error("r0 read returned nonzero");
  a_zero_write_drop: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_i && wr_addr_i == AW'(GPR_ZERO)) |=> bank_r[GPR_ZERO] == '0)
    else $error("write to r0 became visible");
  a_short_base_upd: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_en_i && wr_addr_i == AW'(GPR_EP) |=> short_base_o == $past(wr_data_i))
    else $error("short base pointer not updated from r30");
  a_write_readback: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_en_i && wr_addr_i != AW'(GPR_ZERO) && rd_a_addr_i == wr_addr_i)
    |=> rd_a_o == $past(wr_data_i))
    else $error("general register write not read back");
endmodule
`default_nettype wire

/* File: logic/cpr_regs.sv */
// CPU program and system register set: PC, status word, save sets and register bank.
`default_nettype none
module cpr_regs
  import cpr_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  // General register access
  input  wire logic [GPR_AW-1:0]   gpr_rd_a_addr_i,
  input  wire logic [GPR_AW-1:0]   gpr_rd_b_addr_i,
  input  wire logic                gpr_wr_en_i,
  input  wire logic [GPR_AW-1:0]   gpr_wr_addr_i,
  input  wire logic [XLEN-1:0]     gpr_wr_data_i,
  output logic      [XLEN-1:0]     gpr_rd_a_o,
  output logic      [XLEN-1:0]     gpr_rd_b_o,
  output logic      [XLEN-1:0]     short_base_o,
  // Program counter
  input  wire logic                pc_step_i,
  input  wire logic [STEP_W-1:0]   pc_step_len_i,
  input  wire logic                pc_load_i,
  input  wire logic [XLEN-1:0]     pc_target_i,
  output logic      [XLEN-1:0]     pc_o,
  // Status word flags from the execute stage
  input  wire logic                psw_flag_wr_i,
  input  wire logic [XLEN-1:0]     psw_flags_i,
  output logic      [XLEN-1:0]     psw_o,
  // System register load and store
  input  wire logic                sr_load_i,
  input  wire logic                sr_store_i,
  input  wire cpr_sr_req_t         sr_req_i,
  output logic      [XLEN-1:0]     sr_rdata_o,
  output logic                     sr_refused_o,
  // Events and returns
  input  wire cpr_event_t          event_i,
  input  wire logic                return_from_interrupt_i,
  input  wire logic                debug_trap_return_i,
  // Status toward the pipeline
  output logic      [XLEN-1:0]     table_call_base_o,
  output logic                     debug_window_o
);
  logic [XLEN-1:0] pc_r, psw_r;
  logic [XLEN-1:0] int_pc_r, int_status_r, nmi_pc_r, nmi_status_r;
  logic [XLEN-1:0] cause_r, tc_pc_r, tc_status_r, dbg_pc_r, dbg_status_r, tc_base_r;
  logic            dbg_window_r;
  logic [XLEN-1:0] sr_rdata_r;
  logic            sr_refused_r;

  logic            ev_take, ev_int, ev_nmi, ev_dbg, ev_tc;
  logic            ret_nmi, ret_int, wr_ok, rd_ok;
  logic [PC_AW-1:0] pc_sum;
  logic [XLEN-1:0] sr_view, pc_save, psw_save;

  cpr_gpr_bank u_bank (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .rd_a_addr_i  (gpr_rd_a_addr_i),
    .rd_b_addr_i  (gpr_rd_b_addr_i),
    .rd_a_o       (gpr_rd_a_o),
    .rd_b_o       (gpr_rd_b_o),
    .short_base_o (short_base_o),
    .wr_en_i      (gpr_wr_en_i),
    .wr_addr_i    (gpr_wr_addr_i),
    .wr_data_i    (gpr_wr_data_i)
  );

  assign ev_int  = event_i.kind == EV_MASKABLE || event_i.kind == EV_SW_EXC;
  assign ev_nmi  = event_i.kind == EV_NMI;
  assign ev_dbg  = event_i.kind == EV_DEBUG;
  assign ev_tc   = event_i.kind == EV_TABLE_CALL;
  assign ev_take = event_i.kind != EV_NONE;
  // The NMI-in-service bit decides which save set a return draws on.
  assign ret_nmi = return_from_interrupt_i && psw_r[PSW_NMI_BIT];
  assign ret_int = return_from_interrupt_i && !psw_r[PSW_NMI_BIT];
  assign pc_save  = event_i.resume_pc & PC_SAVE_MASK;
  assign psw_save = psw_r & PSW_MASK;
  // The increment is done in the address width, so a carry out of the top simply falls off.
  assign pc_sum = pc_r[PC_AW-1:0] + PC_AW'(pc_step_len_i);

  // Legal numbers; debug save registers only while the debug window is open.
  function automatic logic sr_legal(input logic [SR_AW-1:0] n, input logic is_load);
    logic ok;
    ok = 1'b0;
    unique case (n)
      SR_INT_PC, SR_INT_STATUS, SR_NMI_PC, SR_NMI_STATUS, SR_STATUS,
      SR_TC_PC, SR_TC_STATUS, SR_TC_BASE: ok = 1'b1;
      SR_CAUSE:                           ok = !is_load;
      SR_DBG_PC, SR_DBG_STATUS:           ok = dbg_window_r;
      default:                            ok = 1'b0;
    endcase
    return ok;
  endfunction

  // A simultaneous event flushes the instruction, so its system register write is dropped.
  assign wr_ok = sr_load_i && sr_legal(sr_req_i.num, 1'b1) && !ev_take;
  assign rd_ok = sr_store_i && sr_legal(sr_req_i.num, 1'b0);

  always_comb begin
    sr_view = WORD_ZERO;
    unique case (sr_req_i.num)
      SR_INT_PC:     sr_view = int_pc_r;
      SR_INT_STATUS: sr_view = int_status_r;
      SR_NMI_PC:     sr_view = nmi_pc_r;
      SR_NMI_STATUS: sr_view = nmi_status_r;
      SR_CAUSE:      sr_view = cause_r;
      SR_STATUS:     sr_view = psw_r;
      SR_TC_PC:      sr_view = tc_pc_r;
      SR_TC_STATUS:  sr_view = tc_status_r;
      SR_DBG_PC:     sr_view = dbg_pc_r;
      SR_DBG_STATUS: sr_view = dbg_status_r;
      SR_TC_BASE:    sr_view = tc_base_r;
      default:       sr_view = WORD_ZERO;
    endcase
  end

  // Program counter: event, return, debug return, jump, then sequential step.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pc_r <= PC_RESET;
    end else if (ev_take) begin
      pc_r <= event_i.handler_pc & PC_MASK;
    end else if (ret_nmi) begin
      pc_r <= nmi_pc_r & PC_MASK;
    end else if (ret_int) begin
      pc_r <= int_pc_r & PC_MASK;
    end else if (debug_trap_return_i) begin
      pc_r <= dbg_pc_r & PC_MASK;
    end else if (pc_load_i) begin
      pc_r <= pc_target_i & PC_MASK;
    end else if (pc_step_i) begin
      pc_r <= XLEN'(pc_sum) & PC_MASK;
    end
  end

  // Status word.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      psw_r <= PSW_RESET;
    end else if (ev_take) begin
      unique case (event_i.kind)
        EV_MASKABLE: psw_r <= psw_r | PSW_SET_MASKABLE;
        EV_SW_EXC:   psw_r <= psw_r | PSW_SET_SW_EXC;
        EV_NMI:      psw_r <= psw_r | PSW_SET_NMI;
        EV_DEBUG:    psw_r <= psw_r | PSW_SET_DEBUG;
        default:     psw_r <= psw_r;
      endcase
    end else if (ret_nmi) begin
      psw_r <= nmi_status_r;
    end else if (ret_int) begin
      psw_r <= int_status_r;
    end else if (debug_trap_return_i) begin
      psw_r <= dbg_status_r;
    end else if (wr_ok && sr_req_i.num == SR_STATUS) begin
      psw_r <= sr_req_i.data & PSW_MASK;
    end else if (psw_flag_wr_i) begin
      psw_r <= psw_flags_i & PSW_MASK;
    end
  end

  // Interrupt and NMI save sets.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      int_pc_r     <= WORD_ZERO;
      int_status_r <= WORD_ZERO;
      nmi_pc_r     <= WORD_ZERO;
      nmi_status_r <= WORD_ZERO;
    end else if (ev_int) begin
      int_pc_r     <= pc_save;
      int_status_r <= psw_save;
    end else if (ev_nmi) begin
      nmi_pc_r     <= pc_save;
      nmi_status_r <= psw_save;
    end else if (wr_ok) begin
      if (sr_req_i.num == SR_INT_PC) int_pc_r <= sr_req_i.data & PC_SAVE_MASK;
      if (sr_req_i.num == SR_INT_STATUS) int_status_r <= sr_req_i.data & PSW_MASK;
      if (sr_req_i.num == SR_NMI_PC) nmi_pc_r <= sr_req_i.data & PC_SAVE_MASK;
      if (sr_req_i.num == SR_NMI_STATUS) nmi_status_r <= sr_req_i.data & PSW_MASK;
    end
  end

  // Cause register has no write path from software at all.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cause_r <= WORD_ZERO;
    end else if (ev_nmi) begin
      cause_r[XLEN-1:ECR_NMI_LSB] <= event_i.code;
    end else if (ev_take && !ev_tc) begin
      cause_r[CODE_W-1:0] <= event_i.code;
    end
  end

  // Table-call set and base pointer.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tc_pc_r     <= WORD_ZERO;
      tc_status_r <= WORD_ZERO;
      tc_base_r   <= WORD_ZERO;
    end else if (ev_tc) begin
      tc_pc_r     <= pc_save;
      tc_status_r <= psw_save;
    end else if (wr_ok) begin
      if (sr_req_i.num == SR_TC_PC) tc_pc_r <= sr_req_i.data & PC_SAVE_MASK;
      if (sr_req_i.num == SR_TC_STATUS) tc_status_r <= sr_req_i.data & PSW_MASK;
      if (sr_req_i.num == SR_TC_BASE) tc_base_r <= sr_req_i.data;
    end
  end

  // Debug save set and the window in which software may reach it.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dbg_pc_r     <= WORD_ZERO;
      dbg_status_r <= WORD_ZERO;
      dbg_window_r <= 1'b0;
    end else if (ev_dbg) begin
      dbg_pc_r     <= pc_save;
      dbg_status_r <= psw_save;
      dbg_window_r <= 1'b1;
    end else begin
      if (debug_trap_return_i) dbg_window_r <= 1'b0;
      if (wr_ok && sr_req_i.num == SR_DBG_PC) dbg_pc_r <= sr_req_i.data & PC_SAVE_MASK;
      if (wr_ok && sr_req_i.num == SR_DBG_STATUS) dbg_status_r <= sr_req_i.data & PSW_MASK;
    end
  end

  // Store answers and refusals, one cycle after the request.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sr_rdata_r   <= WORD_ZERO;
      sr_refused_r <= 1'b0;
    end else begin
      sr_rdata_r   <= rd_ok ? sr_view : WORD_ZERO;
      sr_refused_r <= (sr_load_i && !sr_legal(sr_req_i.num, 1'b1))
                      || (sr_store_i && !rd_ok);
    end
  end

  assign pc_o              = pc_r;
  assign psw_o             = psw_r;
  assign sr_rdata_o        = sr_rdata_r;
  assign sr_refused_o      = sr_refused_r;
  assign table_call_base_o = tc_base_r;
  assign debug_window_o    = dbg_window_r;

  a_pc_fixed_bits: assert property (@(posedge clk_i) disable iff (reset_i)
    (pc_o & ~PC_MASK) == WORD_ZERO)
    else $error("program counter fixed bits not zero");
  a_pc_step_wrap: assert property (@(posedge clk_i) disable iff (reset_i)
    (pc_step_i && !pc_load_i && !ev_take && !return_from_interrupt_i && !debug_trap_return_i)
    |=> pc_o == ((XLEN'($past(pc_o[PC_AW-1:0]) + PC_AW'($past(pc_step_len_i)))) & PC_MASK))
    else $error("program counter step wrong or carry kept");
  a_int_save: assert property (@(posedge clk_i) disable iff (reset_i)
    ev_int |=> int_pc_r == ($past(event_i.resume_pc) & PC_SAVE_MASK)
               && int_status_r == ($past(psw_o) & PSW_MASK))
    else $error("interrupt save set not loaded");
  a_nmi_save: assert property (@(posedge clk_i) disable iff (reset_i)
    ev_nmi |=> nmi_pc_r == ($past(event_i.resume_pc) & PC_SAVE_MASK)
               && $stable(int_pc_r) && psw_o[PSW_NMI_BIT])
    else $error("NMI save set not loaded");
  a_save_bits_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    ((int_pc_r | nmi_pc_r) & ~PC_SAVE_MASK) == WORD_ZERO
    && ((int_status_r | nmi_status_r) & ~PSW_MASK) == WORD_ZERO)
    else $error("save register reserved bits set");
  a_ret_int: assert property (@(posedge clk_i) disable iff (reset_i)
    (ret_int && !ev_take) |=> pc_o == ($past(int_pc_r) & PC_MASK)
                              && psw_o == $past(int_status_r))
    else $error("interrupt return did not restore");
  a_ret_nmi: assert property (@(posedge clk_i) disable iff (reset_i)
    (ret_nmi && !ev_take) |=> pc_o == ($past(nmi_pc_r) & PC_MASK)
                              && psw_o == $past(nmi_status_r))
    else $error("NMI return did not restore");
  a_cause_ro: assert property (@(posedge clk_i) disable iff (reset_i)
    (sr_load_i && sr_req_i.num == SR_CAUSE && !ev_take) |=> sr_refused_o && $stable(cause_r))
    else $error("cause register accepted a write");
  a_cause_record: assert property (@(posedge clk_i) disable iff (reset_i)
    (ev_int || ev_dbg) |=> cause_r[CODE_W-1:0] == $past(event_i.code))
    else $error("exception code not recorded");
  a_tc_save: assert property (@(posedge clk_i) disable iff (reset_i)
    ev_tc |=> tc_pc_r == ($past(event_i.resume_pc) & PC_SAVE_MASK) && $stable(cause_r))
    else $error("table call save wrong");
  a_dbg_window: assert property (@(posedge clk_i) disable iff (reset_i)
    (sr_store_i && sr_req_i.num == SR_DBG_PC && !dbg_window_r) |=> sr_refused_o
                                                                 && sr_rdata_o == WORD_ZERO)
    else $error("debug register reached outside window");
  a_dbg_save: assert property (@(posedge clk_i) disable iff (reset_i)
    ev_dbg |=> dbg_status_r == ($past(psw_o) & PSW_MASK) && debug_window_o)
    else $error("debug trap save wrong");
  a_status_read: assert property (@(posedge clk_i) disable iff (reset_i)
    (sr_store_i && sr_req_i.num == SR_STATUS) |=> sr_rdata_o == $past(psw_o))
    else $error("status word read wrong");
endmodule
`default_nettype wire

/* File: dv/cpr_pipe_model.sv */
// Pipeline model that issues one request at a time to the register block.
`default_nettype none
module cpr_pipe_model
  import cpr_pkg::*;
(
  // Clock
  input  wire logic              clk_i,
  // Requests toward the register block
  output logic                   wr_en_o,
  output logic      [GPR_AW-1:0] wr_addr_o,
  output logic      [XLEN-1:0]   wr_data_o,
  output logic      [GPR_AW-1:0] rd_a_o,
  output logic      [GPR_AW-1:0] rd_b_o,
  output logic                   step_o,
  output logic      [STEP_W-1:0] step_len_o,
  output logic                   jump_o,
  output logic      [XLEN-1:0]   target_o,
  output logic                   flag_wr_o,
  output logic      [XLEN-1:0]   flags_o,
  output logic                   sr_load_o,
  output logic                   sr_store_o,
  output cpr_sr_req_t            sr_req_o,
  output cpr_event_t             event_o,
  output logic                   return_from_interrupt_o,
  output logic                   debug_trap_return_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_en_o, wr_addr_o, wr_data_o, rd_a_o, rd_b_o, step_o, step_len_o, jump_o} = '0;
    {target_o, flag_wr_o, flags_o, sr_load_o, sr_store_o, sr_req_o, event_o} = '0;
    {return_from_interrupt_o, debug_trap_return_o} = '0;
  end
  // Kinds 0 to 8 are strobes and reads, 9 to 13 raise event kinds 1 to 5.
  task automatic op(input int k, input logic [XLEN-1:0] a, input logic [XLEN-1:0] b);
    cpr_event_kind_t kd;
    kd = (k > 8) ? cpr_event_kind_t'(3'(k - 8)) : EV_NONE;
    @(posedge clk_i);
    sr_req_o <= {a[SR_AW-1:0], b};
    wr_addr_o <= a[GPR_AW-1:0];
    wr_data_o <= b;
    target_o <= a;
    flags_o <= b;
    step_len_o <= a[STEP_W-1:0];
    event_o <= {kd, a, b, a[CODE_W-1:0] ^ 16'h00a5};
    case (k)
      // A write also reads the same number back, so the same-cycle pass-through is exercised.
      0: {wr_en_o, rd_a_o} <= {1'b1, a[GPR_AW-1:0]};
      1: sr_load_o <= 1'b1;
      2: sr_store_o <= 1'b1;
      3: step_o <= 1'b1;
      4: jump_o <= 1'b1;
      5: return_from_interrupt_o <= 1'b1;
      6: debug_trap_return_o <= 1'b1;
      7: flag_wr_o <= 1'b1;
      8: {rd_a_o, rd_b_o} <= {a[GPR_AW-1:0], b[GPR_AW-1:0]};
      default: ;
    endcase
    @(posedge clk_i);
    {wr_en_o, sr_load_o, sr_store_o, step_o, jump_o, return_from_interrupt_o, debug_trap_return_o, flag_wr_o} <= '0;
    event_o.kind <= EV_NONE;
    // Released data lines show the inverse so a stale value cannot pass for a hold.
    wr_data_o <= ~b;
    sr_req_o.data <= ~b;
    #1;
  endtask
endmodule
`default_nettype wire

/* File: dv/cpr_regs_tb_top.sv */
// Self-checking bench for the program and system register block.
`default_nettype none
module cpr_regs_tb_top
  import cpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [XLEN-1:0] PSET [6] = '{32'h0, PSW_SET_MASKABLE, PSW_SET_SW_EXC,
                                           PSW_SET_NMI, PSW_SET_DEBUG, 32'h0};
  localparam int SAVE_PC [6] = '{0, 0, 0, 2, 18, 16};
  logic              clk_i, reset_i, rf, dw;
  wire logic         we, st, jp, fw, sl, ss, ri, dr;
  wire logic [4:0]   wa, ra, rb;
  wire logic [2:0]   sn;
  wire logic [31:0]  wd, tg, fv;
  wire cpr_sr_req_t  req;
  wire cpr_event_t   ev;
  logic [XLEN-1:0]   qa, qb, sb, pc, ps, rd, tb, seed, pm, sm, cm, d, r;
  logic [XLEN:0]     e;
  logic [XLEN-1:0]   gm [GPR_COUNT];
  int                err_total, total_checks, k, n;
  cpr_pipe_model i_cpr_pipe_model (.clk_i(clk_i), .wr_en_o(we), .wr_addr_o(wa),
    .wr_data_o(wd), .rd_a_o(ra), .rd_b_o(rb), .step_o(st), .step_len_o(sn), .jump_o(jp),
    .target_o(tg), .flag_wr_o(fw), .flags_o(fv), .sr_load_o(sl), .sr_store_o(ss),
    .sr_req_o(req), .event_o(ev), .return_from_interrupt_o(ri), .debug_trap_return_o(dr));
  cpr_regs i_cpr_regs (.clk_i(clk_i), .reset_i(reset_i), .gpr_rd_a_addr_i(ra),
    .gpr_rd_b_addr_i(rb), .gpr_wr_en_i(we), .gpr_wr_addr_i(wa), .gpr_wr_data_i(wd),
    .gpr_rd_a_o(qa), .gpr_rd_b_o(qb), .short_base_o(sb), .pc_step_i(st),
    .pc_step_len_i(sn), .pc_load_i(jp), .pc_target_i(tg), .pc_o(pc), .psw_flag_wr_i(fw),
    .psw_flags_i(fv), .psw_o(ps), .sr_load_i(sl), .sr_store_i(ss), .sr_req_i(req),
    .sr_rdata_o(rd), .sr_refused_o(rf), .event_i(ev), .return_from_interrupt_i(ri), .debug_trap_return_i(dr),
    .table_call_base_o(tb), .debug_window_o(dw));
  function automatic logic [XLEN-1:0] lfsr_next(input logic [XLEN-1:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Refused flag on top of the data a store returns; the cause register is still clear here.
  function automatic logic [XLEN:0] sr_exp(input int n, input logic [XLEN-1:0] v, input bit ld);
    if (n > 20 || (n > 5 && n < 16) || n == 18 || n == 19 || (ld && n == 4))
      return {1'b1, WORD_ZERO};
    if (n == 4)
      return {1'b0, WORD_ZERO};
    if (n == 1 || n == 3 || n == 5 || n == 17)
      return {1'b0, v & PSW_MASK};
    return {1'b0, v & PC_SAVE_MASK};
  endfunction
  task automatic chk(input logic [XLEN-1:0] seen, input logic [XLEN-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input int k, input logic [XLEN-1:0] a, input logic [XLEN-1:0] b);
    i_cpr_pipe_model.op(k, a, b);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    test_done();
  end
  initial begin
    reset_i = 1'b1;
    err_total = 0;
    total_checks = 0;
    seed = 32'h0000_4097;
    for (k = 0; k < GPR_COUNT; k++) gm[k] = WORD_ZERO;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    chk(pc, PC_RESET);
    chk(ps, PSW_RESET);
    chk({31'h0, dw}, 32'h0);
    $display("test reset done");
    // Register zero and the short-access base are forced into the first two writes.
    for (k = 0; k < 16; k++) begin
      seed = lfsr_next(seed);
      n = (k == 0) ? 0 : (k == 1) ? 30 : int'(seed[4:0]);
      op(0, 32'(n), seed);
      if (n != 0) gm[n] = seed;
      op(8, 32'(n), 32'h1e);
      chk(qa, gm[n]);
      chk(qb, gm[30]);
      chk(sb, gm[30]);
    end
    $display("test gpr done");
    op(4, 32'hffff_ffff, 32'h0);
    chk(pc, 32'h03ff_fffe);
    op(3, 32'h2, 32'h0);
    chk(pc, WORD_ZERO);
    pm = WORD_ZERO;
    for (k = 0; k < 8; k++) begin
      seed = lfsr_next(seed);
      op(3, seed, 32'h0);
      pm = (pm + {29'h0, seed[2:0]}) & PC_MASK;
      chk(pc, pm);
    end
    seed = lfsr_next(seed);
    op(7, 32'h0, seed);
    chk(ps, seed & PSW_MASK);
    $display("test pc done");
    for (k = 0; k < 32; k++) begin
      seed = lfsr_next(seed);
      d = (k == 20) ? (seed & PC_MASK) : seed;
      op(1, 32'(k), d);
      e = sr_exp(k, d, 1'b1);
      chk({31'h0, rf}, {31'h0, e[XLEN]});
      op(2, 32'(k), 32'h0);
      e = sr_exp(k, d, 1'b0);
      chk({31'h0, rf}, {31'h0, e[XLEN]});
      chk(rd, e[XLEN-1:0]);
      if (k == 20) chk(tb, d);
    end
    $display("test sysreg done");
    cm = WORD_ZERO;
    for (k = 1; k < 6; k++) begin
      seed = lfsr_next(seed);
      sm = seed & 32'h0000_007f;
      op(1, 32'h5, sm);
      r = lfsr_next(seed);
      op(8 + k, r, ~r);
      chk(pc, ~r & PC_MASK);
      chk(ps, sm | PSET[k]);
      chk({31'h0, dw}, {31'h0, k == 4});
      op(2, 32'(SAVE_PC[k]), 32'h0);
      chk(rd, r & PC_SAVE_MASK);
      op(2, 32'(SAVE_PC[k] + 1), 32'h0);
      chk(rd, sm);
      if (k == 3) cm[31:16] = r[15:0] ^ 16'h00a5;
      else if (k != 5) cm[15:0] = r[15:0] ^ 16'h00a5;
      op(2, 32'h4, 32'h0);
      chk(rd, cm);
      if (k < 5) begin
        op((k == 4) ? 6 : 5, 32'h0, 32'h0);
        chk(pc, r & PC_MASK);
        chk(ps, sm);
      end
    end
    op(2, 32'h12, 32'h0);
    chk({31'h0, rf}, 32'h1);
    op(9, 32'h200, 32'h0);
    op(1, 32'h0, 32'h0000_0301);
    op(5, 32'h0, 32'h0);
    chk(pc, 32'h0000_0300);
    $display("test events done");
    test_done();
  end
endmodule
`default_nettype wire
